// ---- src/snsd_node.sv ----
// Scan node: state decode, virtual instruction register and AHB-Lite status access
//
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "snsd_cfg.svh"

module snsd_node #(
  parameter int    NODE_INSTR_WIDTH = 1,
  parameter string AUTO_INDEX       = "YES",
  parameter int    INSTANCE_INDEX   = 0,
  parameter int    AUTO_SLOT        = 0
) (
  // System clock and reset
  input  wire  logic                          clk,
  input  wire  logic                          rst,
  // AHB-Lite slave
  input  wire  logic                          hsel,
  input  wire  logic [31:0]                   haddr,
  input  wire  logic [1:0]                    htrans,
  input  wire  logic                          hwrite,
  input  wire  logic [2:0]                    hsize,
  input  wire  logic [31:0]                   hwdata,
  input  wire  logic                          hready,
  output logic       [31:0]                   hrdata,
  output logic                                hreadyout,
  output logic                                hresp,
  // Index clash source, system clock
  input  wire  logic [7:0]                    peer_index,
  // Test link, test clock domain
  input  wire  logic                          tck,
  input  wire  logic                          tms,
  input  wire  logic                          tdi,
  output logic                                tdo,
  input  wire  logic [7:0]                    hub_node_addr,
  input  wire  logic                          hub_vir_sel,
  // User glue, test clock domain
  input  wire  logic                          user_tdo,
  input  wire  logic [NODE_INSTR_WIDTH-1:0]   vinstr_parallel_load,
  output logic       [NODE_INSTR_WIDTH-1:0]   vinstr_parallel_out,
  output snsd_pkg::snsd_vstate_s              vstate,
  output snsd_pkg::snsd_tap_ind_s             tap_ind,
  output logic                                tms_copy
);
  import snsd_pkg::*;

  // ----------------------------------------------------------------
  // Test clock reset release
  // ----------------------------------------------------------------
  logic tck_rst_a_reg;
  logic tck_rst_b_reg;
  logic tck_rst;

  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      tck_rst_a_reg <= 1'b0;
      tck_rst_b_reg <= 1'b0;
    end else begin
      tck_rst_a_reg <= 1'b1;
      tck_rst_b_reg <= tck_rst_a_reg;
    end
  end

  // Assert follows rst at once, release waits two tck edges
  assign tck_rst = ~tck_rst_b_reg;

  // ----------------------------------------------------------------
  // Controller state machine
  // ----------------------------------------------------------------
  snsd_tap_e tap_reg;
  snsd_tap_e tap_next;

  always_comb begin
    case (tap_reg)
      TAP_RESET:    tap_next = tms ? TAP_RESET    : TAP_IDLE;
      TAP_IDLE:     tap_next = tms ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_DR:   tap_next = tms ? TAP_SEL_IR   : TAP_CAP_DR;
      TAP_CAP_DR:   tap_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: tap_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: tap_next = tms ? TAP_UPD_DR   : TAP_PAUSE_DR;
      TAP_PAUSE_DR: tap_next = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: tap_next = tms ? TAP_UPD_DR   : TAP_SHIFT_DR;
      TAP_UPD_DR:   tap_next = tms ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_IR:   tap_next = tms ? TAP_RESET    : TAP_CAP_IR;
      TAP_CAP_IR:   tap_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: tap_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: tap_next = tms ? TAP_UPD_IR   : TAP_PAUSE_IR;
      TAP_PAUSE_IR: tap_next = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: tap_next = tms ? TAP_UPD_IR   : TAP_SHIFT_IR;
      TAP_UPD_IR:   tap_next = tms ? TAP_SEL_DR   : TAP_IDLE;
      default:      tap_next = TAP_RESET;
    endcase
  end

  always_ff @(posedge tck or posedge tck_rst) begin
    if (tck_rst) begin
      tap_reg <= TAP_RESET;
    end else begin
      tap_reg <= tap_next;
    end
  end

  // ----------------------------------------------------------------
  // Indicator decode, registered so outputs move only on tck
  // ----------------------------------------------------------------
  logic [`SNSD_IDX_W-1:0] idx_tck_reg;
  logic                   node_sel;
  snsd_tap_ind_s          tap_ind_next;
  snsd_vstate_s           vstate_next;
  snsd_tap_ind_s          tap_ind_reg;
  snsd_vstate_s           vstate_reg;
  logic                   tms_copy_reg;

  assign node_sel = (hub_node_addr == idx_tck_reg);

  always_comb begin
    tap_ind_next              = '0;
    tap_ind_next.tap_reset    = (tap_next == TAP_RESET);
    tap_ind_next.tap_idle     = (tap_next == TAP_IDLE);
    tap_ind_next.tap_sel_dr   = (tap_next == TAP_SEL_DR);
    tap_ind_next.tap_cap_dr   = (tap_next == TAP_CAP_DR);
    tap_ind_next.tap_shift_dr = (tap_next == TAP_SHIFT_DR);
    tap_ind_next.tap_exit1_dr = (tap_next == TAP_EXIT1_DR);
    tap_ind_next.tap_pause_dr = (tap_next == TAP_PAUSE_DR);
    tap_ind_next.tap_exit2_dr = (tap_next == TAP_EXIT2_DR);
    tap_ind_next.tap_upd_dr   = (tap_next == TAP_UPD_DR);
    tap_ind_next.tap_sel_ir   = (tap_next == TAP_SEL_IR);
    tap_ind_next.tap_cap_ir   = (tap_next == TAP_CAP_IR);
    tap_ind_next.tap_shift_ir = (tap_next == TAP_SHIFT_IR);
    tap_ind_next.tap_exit1_ir = (tap_next == TAP_EXIT1_IR);
    tap_ind_next.tap_pause_ir = (tap_next == TAP_PAUSE_IR);
    tap_ind_next.tap_exit2_ir = (tap_next == TAP_EXIT2_IR);
    tap_ind_next.tap_upd_ir   = (tap_next == TAP_UPD_IR);
  end

  // Virtual scans ride inside device data scans; hub_vir_sel picks the column
  always_comb begin
    vstate_next                  = '0;
    if (node_sel) begin
      if (hub_vir_sel) begin
        vstate_next.vnode_cap_instr  = tap_ind_next.tap_cap_dr;
        vstate_next.vnode_upd_instr  = tap_ind_next.tap_upd_dr;
      end else begin
        vstate_next.vnode_cap_data   = tap_ind_next.tap_cap_dr;
        vstate_next.vnode_shift_data = tap_ind_next.tap_shift_dr;
        vstate_next.vnode_exit1_data = tap_ind_next.tap_exit1_dr;
        vstate_next.vnode_pause_data = tap_ind_next.tap_pause_dr;
        vstate_next.vnode_exit2_data = tap_ind_next.tap_exit2_dr;
        vstate_next.vnode_upd_data   = tap_ind_next.tap_upd_dr;
      end
    end
  end

  always_ff @(posedge tck or posedge tck_rst) begin
    if (tck_rst) begin
      tap_ind_reg <= '0;
      vstate_reg  <= '0;
    end else begin
      tap_ind_reg <= tap_ind_next;
      vstate_reg  <= vstate_next;
    end
  end

  // Informational only, not used by any node logic
  always_ff @(posedge tck or posedge tck_rst) begin
    if (tck_rst) begin
      tms_copy_reg <= 1'b0;
    end else begin
      tms_copy_reg <= tms;
    end
  end

  // ----------------------------------------------------------------
  // Virtual instruction register
  // ----------------------------------------------------------------
  logic [NODE_INSTR_WIDTH-1:0] vir_shift_reg;
  logic [NODE_INSTR_WIDTH-1:0] vir_shift_next;
  logic [NODE_INSTR_WIDTH-1:0] vinstr_out_reg;
  logic                        vir_shifting;
  logic                        tdo_reg;

  assign vir_shifting = node_sel && hub_vir_sel && (tap_reg == TAP_SHIFT_DR);

  // Loop form keeps the one-bit register legal
  always_comb begin
    vir_shift_next = vir_shift_reg;
    for (int i = 0; i < NODE_INSTR_WIDTH - 1; i++) begin
      vir_shift_next[i] = vir_shift_reg[i+1];
    end
    vir_shift_next[NODE_INSTR_WIDTH-1] = tdi;
  end

  always_ff @(posedge tck or posedge tck_rst) begin
    if (tck_rst) begin
      vir_shift_reg <= '0;
    end else if (vstate_reg.vnode_cap_instr) begin
      vir_shift_reg <= vinstr_parallel_load;
    end else if (vir_shifting) begin
      vir_shift_reg <= vir_shift_next;
    end
  end

  always_ff @(posedge tck or posedge tck_rst) begin
    if (tck_rst) begin
      vinstr_out_reg <= '0;
    end else if (vstate_reg.vnode_upd_instr) begin
      vinstr_out_reg <= vir_shift_reg;
    end
  end

  // ----------------------------------------------------------------
  // Serial return path
  // ----------------------------------------------------------------
  // One bypass stage when idle, so the chain never opens
  always_ff @(posedge tck or posedge tck_rst) begin
    if (tck_rst) begin
      tdo_reg <= 1'b0;
    end else if (vstate_reg.vnode_shift_data) begin
      tdo_reg <= user_tdo;
    end else if (vir_shifting) begin
      tdo_reg <= vir_shift_reg[0];
    end else begin
      tdo_reg <= tdi;
    end
  end

  assign tdo                 = tdo_reg;
  assign vinstr_parallel_out = vinstr_out_reg;
  assign vstate              = vstate_reg;
  assign tap_ind             = tap_ind_reg;
  assign tms_copy            = tms_copy_reg;

  // ----------------------------------------------------------------
  // Index handshake, system clock to test clock
  // ----------------------------------------------------------------
  logic                   auto_reg;
  logic [`SNSD_IDX_W-1:0] manual_idx_reg;
  logic [`SNSD_IDX_W-1:0] eff_idx_reg;
  logic [`SNSD_IDX_W-1:0] eff_idx_next;
  logic [`SNSD_IDX_W-1:0] idx_hold_reg;
  logic                   req_tgl_reg;
  logic                   ack_s1_reg;
  logic                   ack_s2_reg;
  logic                   ack_s3_reg;
  logic                   ack_seen_reg;
  logic                   rq_s1_reg;
  logic                   rq_s2_reg;
  logic                   rq_s3_reg;
  logic                   rq_seen_reg;

  // Clash falls back to the build-time free slot
  always_comb begin
    if (auto_reg) begin
      eff_idx_next = AUTO_SLOT[`SNSD_IDX_W-1:0];
    end else if (manual_idx_reg == peer_index) begin
      eff_idx_next = AUTO_SLOT[`SNSD_IDX_W-1:0];
    end else begin
      eff_idx_next = manual_idx_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      eff_idx_reg <= `SNSD_IDX_RST;
    end else begin
      eff_idx_reg <= eff_idx_next;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
      ack_s3_reg <= 1'b0;
    end else begin
      ack_s1_reg <= rq_seen_reg;
      ack_s2_reg <= ack_s1_reg;
      ack_s3_reg <= ack_s2_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_seen_reg <= 1'b0;
    end else if (ack_s2_reg == ack_s3_reg) begin
      ack_seen_reg <= ack_s3_reg;
    end
  end

  // Hold word changes only once the previous one is acknowledged
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idx_hold_reg <= `SNSD_IDX_RST;
      req_tgl_reg  <= 1'b0;
    end else if ((ack_seen_reg == req_tgl_reg) && (eff_idx_reg != idx_hold_reg)) begin
      idx_hold_reg <= eff_idx_reg;
      req_tgl_reg  <= ~req_tgl_reg;
    end
  end

  always_ff @(posedge tck or posedge tck_rst) begin
    if (tck_rst) begin
      rq_s1_reg <= 1'b0;
      rq_s2_reg <= 1'b0;
      rq_s3_reg <= 1'b0;
    end else begin
      rq_s1_reg <= req_tgl_reg;
      rq_s2_reg <= rq_s1_reg;
      rq_s3_reg <= rq_s2_reg;
    end
  end

  always_ff @(posedge tck or posedge tck_rst) begin
    if (tck_rst) begin
      rq_seen_reg <= 1'b0;
      idx_tck_reg <= `SNSD_IDX_RST;
    end else if ((rq_s2_reg == rq_s3_reg) && (rq_s3_reg != rq_seen_reg)) begin
      rq_seen_reg <= rq_s3_reg;
      idx_tck_reg <= idx_hold_reg;
    end
  end

  // ----------------------------------------------------------------
  // Status crossing, test clock to system clock
  // ----------------------------------------------------------------
  localparam int STAT_W = 16 + 8 + `SNSD_VIR_MAX;

  logic [STAT_W-1:0] stat_src;
  logic [STAT_W-1:0] stat_s1_reg;
  logic [STAT_W-1:0] stat_s2_reg;
  logic [STAT_W-1:0] stat_s3_reg;
  logic [STAT_W-1:0] stat_reg;

  // Bits settle independently; software sees a snapshot, not a coherent word
  always_comb begin
    stat_src                             = '0;
    stat_src[15:0]                       = tap_ind_reg;
    stat_src[23:16]                      = vstate_reg;
    stat_src[24+NODE_INSTR_WIDTH-1:24]   = vinstr_out_reg;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stat_s1_reg <= '0;
      stat_s2_reg <= '0;
      stat_s3_reg <= '0;
    end else begin
      stat_s1_reg <= stat_src;
      stat_s2_reg <= stat_s1_reg;
      stat_s3_reg <= stat_s2_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= (stat_s2_reg & stat_s3_reg) | (stat_reg & (stat_s2_reg ^ stat_s3_reg));
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------------------------------
  logic                   addr_ok;
  logic                   wr_pend_reg;
  logic [`SNSD_ADDR_W-1:0] wr_addr_reg;
  logic [31:0]            rd_mux;
  logic [31:0]            hrdata_reg;
  logic                   hreadyout_reg;
  logic                   hresp_reg;

  assign addr_ok = hsel && hready && htrans[1] && (hsize == `SNSD_HSIZE_WORD);

  always_comb begin
    rd_mux = `SNSD_ZERO32;
    case (haddr[`SNSD_ADDR_W-1:0])
      `SNSD_OFS_CTRL: begin
        rd_mux[`SNSD_CTRL_AUTO_BIT]                   = auto_reg;
        rd_mux[`SNSD_CTRL_IDX_MSB:`SNSD_CTRL_IDX_LSB] = manual_idx_reg;
      end
      `SNSD_OFS_TAP_STAT: rd_mux[15:0]              = stat_reg[15:0];
      `SNSD_OFS_VSTATE:   rd_mux[7:0]               = stat_reg[23:16];
      `SNSD_OFS_VINSTR:   rd_mux[`SNSD_VIR_MAX-1:0] = stat_reg[STAT_W-1:24];
      `SNSD_OFS_INDEX:    rd_mux[`SNSD_IDX_W-1:0]   = eff_idx_reg;
      default:            rd_mux                    = `SNSD_ZERO32;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata_reg    <= `SNSD_ZERO32;
      hreadyout_reg <= 1'b0;
      hresp_reg     <= `SNSD_HRESP_OKAY;
    end else begin
      hreadyout_reg <= 1'b1;
      hresp_reg     <= `SNSD_HRESP_OKAY;
      if (addr_ok && !hwrite) begin
        hrdata_reg <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
    end else if (hready) begin
      wr_pend_reg <= addr_ok && hwrite;
      wr_addr_reg <= haddr[`SNSD_ADDR_W-1:0];
    end
  end

  // Only the control word is writable; other writes are dropped with OKAY
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      auto_reg       <= (AUTO_INDEX == "YES");
      manual_idx_reg <= INSTANCE_INDEX[`SNSD_IDX_W-1:0];
    end else if (wr_pend_reg && (wr_addr_reg == `SNSD_OFS_CTRL)) begin
      auto_reg       <= hwdata[`SNSD_CTRL_AUTO_BIT];
      manual_idx_reg <= hwdata[`SNSD_CTRL_IDX_MSB:`SNSD_CTRL_IDX_LSB];
    end
  end

  assign hrdata    = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp     = hresp_reg;

  // Width stays within the documented range of one to twenty-four
  if (NODE_INSTR_WIDTH < 1 || NODE_INSTR_WIDTH > `SNSD_VIR_MAX) begin : g_bad_width
    $error("instruction width out of range");
  end

endmodule

// ---- src/snsd_cfg.svh ----
// Address map, field positions and reset values of the scan node
`ifndef SNSD_CFG_SVH
`define SNSD_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SNSD_ADDR_W         8
`define SNSD_OFS_CTRL       8'h00
`define SNSD_OFS_TAP_STAT   8'h04
`define SNSD_OFS_VSTATE     8'h08
`define SNSD_OFS_VINSTR     8'h0C
`define SNSD_OFS_INDEX      8'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SNSD_CTRL_AUTO_BIT  0
`define SNSD_CTRL_IDX_LSB   8
`define SNSD_CTRL_IDX_MSB   15
`define SNSD_IDX_W          8
`define SNSD_VIR_MAX        24

// ----------------------------------------------------------------
// Bus encodings and reset values
// ----------------------------------------------------------------
`define SNSD_HSIZE_WORD     3'h2
`define SNSD_HRESP_OKAY     1'b0
`define SNSD_ZERO32         32'h0000_0000
`define SNSD_IDX_RST        8'h00

`endif

// ---- src/snsd_pkg.sv ----
// Types shared by the scan node design and its bench
package snsd_pkg;

  // ----------------------------------------------------------------
  // Test-access-port controller states
  // ----------------------------------------------------------------
  typedef enum {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } snsd_tap_e;

  // ----------------------------------------------------------------
  // One-hot indicator groups
  // ----------------------------------------------------------------
  typedef struct packed {
    logic tap_reset;
    logic tap_idle;
    logic tap_sel_dr;
    logic tap_cap_dr;
    logic tap_shift_dr;
    logic tap_exit1_dr;
    logic tap_pause_dr;
    logic tap_exit2_dr;
    logic tap_upd_dr;
    logic tap_sel_ir;
    logic tap_cap_ir;
    logic tap_shift_ir;
    logic tap_exit1_ir;
    logic tap_pause_ir;
    logic tap_exit2_ir;
    logic tap_upd_ir;
  } snsd_tap_ind_s;

  typedef struct packed {
    logic vnode_cap_data;
    logic vnode_shift_data;
    logic vnode_exit1_data;
    logic vnode_pause_data;
    logic vnode_exit2_data;
    logic vnode_upd_data;
    logic vnode_cap_instr;
    logic vnode_upd_instr;
  } snsd_vstate_s;

endpackage

// ---- bench/snsd_node_sva.sv ----
// Assertions on the scan node's link-side outputs
`timescale 1ns/1ps
module snsd_node_sva #(
  parameter int NODE_INSTR_WIDTH = 1
) (
  // Link clock and reset
  input wire logic                        tck,
  input wire logic                        rst,
  // Serial pins
  input wire logic                        tms,
  input wire logic                        tdo,
  input wire logic                        user_tdo,
  // Decoded outputs
  input wire logic [NODE_INSTR_WIDTH-1:0] vinstr_parallel_out,
  input wire snsd_pkg::snsd_vstate_s      vstate,
  input wire snsd_pkg::snsd_tap_ind_s     tap_ind,
  input wire logic                        tms_copy
);
  import snsd_pkg::*;
  // ----------------------------------------------------------------
  // Edge count: controller lags reset release by two edges
  // ----------------------------------------------------------------
  logic [2:0] live_cnt;
  always_ff @(posedge tck or posedge rst) begin
    if (rst)
      live_cnt <= 3'h0;
    else if (live_cnt != 3'h7)
      live_cnt <= live_cnt + 3'h1;
  end
  default clocking cb @(posedge tck); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_vstate_onehot: assert property ($onehot0(vstate))
    else $error("virtual indicators overlap");
  a_tms_mirror: assert property (live_cnt == 3'h7 |-> tms_copy == $past(tms))
    else $error("mode-select copy wrong");
  a_shift_path: assert property
    (vstate.vnode_shift_data && $past(vstate.vnode_shift_data) |-> tdo == $past(user_tdo))
    else $error("serial path broken");
  a_dr_column: assert property
    (tap_ind.tap_cap_dr |=> (tms_copy ? tap_ind.tap_exit1_dr : tap_ind.tap_shift_dr))
    else $error("data column step wrong");
  a_ir_column: assert property
    (tap_ind.tap_sel_ir |=> (tms_copy ? tap_ind.tap_reset : tap_ind.tap_cap_ir))
    else $error("instruction column step wrong");
  a_vcap_match: assert property
    (vstate.vnode_cap_data || vstate.vnode_cap_instr |-> tap_ind.tap_cap_dr)
    else $error("capture indicator off state");
  a_vupd_match: assert property
    (vstate.vnode_upd_data || vstate.vnode_upd_instr |-> tap_ind.tap_upd_dr)
    else $error("update indicator off state");
  a_vmid_match: assert property
    (({vstate.vnode_exit1_data, vstate.vnode_pause_data, vstate.vnode_exit2_data}
      & ~{tap_ind.tap_exit1_dr, tap_ind.tap_pause_dr, tap_ind.tap_exit2_dr}) == 3'h0)
    else $error("exit or pause indicator off state");
  a_vir_hold: assert property
    (!$past(vstate.vnode_upd_instr) |-> $stable(vinstr_parallel_out))
    else $error("instruction output moved");
endmodule

bind snsd_node snsd_node_sva #(.NODE_INSTR_WIDTH(NODE_INSTR_WIDTH)) u_sva (
  .tck, .rst, .tms, .tdo, .user_tdo, .vinstr_parallel_out, .vstate, .tap_ind, .tms_copy);

// ---- bench/snsd_glue_model.sv ----
// Behavioural user glue: one data chain and a fixed instruction load value
`timescale 1ns/1ps
module snsd_glue_model #(
  parameter int          W    = 1,
  parameter logic [23:0] LOAD = 24'h00_0001,
  parameter logic [7:0]  CAP  = 8'h3C
) (
  // Link clock and reset
  input  wire logic                   tck,
  input  wire logic                   rst,
  // Node side
  input  wire logic                   tdi,
  input  wire snsd_pkg::snsd_vstate_s vstate,
  output logic                        user_tdo,
  output logic [W-1:0]                vinstr_parallel_load,
  // Latched chain value for the bench
  output logic [7:0]                  dr_out
);
  import snsd_pkg::*;
  logic [7:0] chain_reg;
  // Held steady, so any capture edge sees it
  assign vinstr_parallel_load = LOAD[W-1:0];
  assign user_tdo = chain_reg[0];
  // Pause and exit states simply hold the chain
  always_ff @(posedge tck or posedge rst) begin
    if (rst)
      chain_reg <= 8'h00;
    else if (vstate.vnode_cap_data)
      chain_reg <= CAP;
    else if (vstate.vnode_shift_data)
      chain_reg <= {tdi, chain_reg[7:1]};
  end
  always_ff @(posedge tck or posedge rst) begin
    if (rst)
      dr_out <= 8'h00;
    else if (vstate.vnode_upd_data)
      dr_out <= chain_reg;
  end
endmodule

// ---- bench/testbench.sv ----
// Self-checking bench: bus reads, controller walks and virtual scans
`timescale 1ns/1ps
`include "snsd_cfg.svh"
module testbench;
  import snsd_pkg::*;
  logic          clk = 1'b0, tck = 1'b0, rst = 1'b1, hwrite = 1'b0;
  logic          tms = 1'b1, tdi = 1'b0, vir_sel = 1'b0;
  logic [1:0]    htrans = 2'h0;
  logic [2:0]    hsize_v = `SNSD_HSIZE_WORD;
  logic [31:0]   haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd_val;
  logic [7:0]    peer = 8'h07, node_addr = 8'h00, dr_out;
  logic          hreadyout, hresp, tdo, user_tdo, tms_copy;
  logic [3:0]    vin_load, vin_out;
  snsd_vstate_s  vstate;
  snsd_tap_ind_s tap_ind;
  int            err_count = 0, tests_run = 0, cyc = 0;
  logic [17:0]   wt = 18'h1_A7A5;
  int            ws[18] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 2, 9, 10, 11, 12, 13, 14, 15, 1};

  initial forever #12.5 clk = ~clk;
  initial begin
    #7;
    forever #24 tck = ~tck;
  end

  snsd_node #(.NODE_INSTR_WIDTH(4), .AUTO_INDEX("YES"), .INSTANCE_INDEX(3), .AUTO_SLOT(0)) uut (
    .clk(clk), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize_v), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .peer_index(peer), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .hub_node_addr(node_addr), .hub_vir_sel(vir_sel),
    .user_tdo(user_tdo), .vinstr_parallel_load(vin_load), .vinstr_parallel_out(vin_out),
    .vstate(vstate), .tap_ind(tap_ind), .tms_copy(tms_copy));

  snsd_glue_model #(.W(4), .LOAD(24'h00_0009)) u_glue (.tck(tck), .rst(rst), .tdi(tdi),
    .vstate(vstate), .user_tdo(user_tdo), .vinstr_parallel_load(vin_load), .dr_out(dr_out));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd_val = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0000_0000);
    chk(rd_val, e);
    chk({31'h0000_0000, hresp}, 32'h0000_0000);
  endtask
  // Each bit is driven, then sampled by the next rising edge
  task automatic run(input int n, input logic [15:0] t, input logic [15:0] d);
    for (int i = 0; i < n; i++) begin
      tms <= t[i];
      tdi <= d[i];
      @(posedge tck);
    end
  endtask
  function automatic logic [7:0] vexp(input int s, input logic on, input logic ir);
    if (!on)
      return 8'h00;
    if (ir)
      return (s == 3) ? 8'h02 : (s == 8) ? 8'h01 : 8'h00;
    return (s >= 3 && s <= 8) ? 8'h80 >> (s - 3) : 8'h00;
  endfunction
  task automatic walk(input logic [7:0] a, input logic ir);
    node_addr <= a;
    vir_sel <= ir;
    run(5, 16'h001F, 16'h0000);
    for (int i = 0; i < 18; i++) begin
      run(1, {15'h0000, wt[i]}, 16'h0000);
      @(negedge tck);
      chk({16'h0000, tap_ind}, 32'h0000_8000 >> ws[i]);
      chk({24'h00_0000, vstate}, {24'h00_0000, vexp(ws[i], a == 8'h03, ir)});
      chk({31'h0000_0000, tms_copy}, {31'h0000_0000, wt[i]});
    end
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      wrap_up();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(`SNSD_OFS_CTRL, 32'h0000_0301);
    rd(`SNSD_OFS_INDEX, 32'h0000_0000);
    ahb(1'b1, `SNSD_OFS_CTRL, 32'h0000_0300);
    rd(`SNSD_OFS_INDEX, 32'h0000_0003);
    peer <= 8'h03;
    repeat (4) @(posedge clk);
    rd(`SNSD_OFS_INDEX, 32'h0000_0000);
    peer <= 8'h07;
    ahb(1'b1, 8'h40, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0000_0000);
    rd(`SNSD_OFS_INDEX, 32'h0000_0003);
    repeat (20) @(posedge clk);
    walk(8'h03, 1'b0);
    walk(8'h03, 1'b1);
    walk(8'h05, 1'b0);
    // Capture then update with no shift: output shows the load value
    node_addr <= 8'h03;
    vir_sel <= 1'b1;
    run(5, 16'h000D, 16'h0000);
    @(negedge tck);
    chk({28'h000_0000, vin_out}, 32'h0000_0009);
    run(7, 16'h0041, 16'h0030);
    @(negedge tck);
    chk({28'h000_0000, vin_out}, 32'h0000_0009);
    run(2, 16'h0001, 16'h0000);
    @(negedge tck);
    chk({28'h000_0000, vin_out}, 32'h0000_0006);
    // Status crosses through four flops (three synchroniser stages and the filter) before the bus can see it
    repeat (6) @(posedge clk);
    rd(`SNSD_OFS_VINSTR, 32'h0000_0006);
    vir_sel <= 1'b0;
    run(12, 16'h3401, 16'h0528);
    repeat (6) @(posedge clk);
    rd(`SNSD_OFS_VSTATE, 32'h0000_0010);
    rd(`SNSD_OFS_TAP_STAT, 32'h0000_0200);
    run(3, 16'h0003, 16'h0000);
    @(negedge tck);
    chk({24'h00_0000, dr_out}, 32'h0000_00A5);
    wrap_up();
  end
endmodule
